// file: vme_pkg.sv
// Package of constants and carrier types for the voting memory ECC interface.
package vme_pkg;
    localparam int BUS_W = 11;
    localparam int NUM_BUS = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int HAM_W = 6;
    localparam int CODE_W = 38;
    localparam int WORD_W = 39;
    localparam int ADDR_BEATS = 2;
    localparam int DATA_BEATS = 3;
    localparam logic [3:0] FLT_NONE = 4'h0;
    localparam logic [3:0] FLT_IOP_BASE = 4'h4;
    localparam logic [3:0] FLT_PE_BASE = 4'h8;
    localparam logic [3:0] FLT_INTERNAL = 4'hf;
    localparam logic [1:0] SEL_RESET = 2'h0;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_WDATA = 6'b000100,
        ST_WRITE = 6'b001000,
        ST_READ = 6'b010000,
        ST_OUT = 6'b100000
    } vme_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [NUM_BUS-1:0] grant;
        logic io_req;
        logic [1:0] out_assign;
        logic clear_mode;
    } vme_req_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } vme_core_req_t;

    typedef struct packed {
        vme_state_t st;
        logic [1:0] beat;
        logic wr;
        logic [NUM_BUS-1:0] grant;
        logic io_req;
        logic [1:0] out_bus;
        logic clear_mode;
        logic [ADDR_W:0] addr;
        logic [DATA_W:0] data;
        logic [DATA_W:0] rdata;
        logic bad;
        logic [NUM_BUS-1:0] vflt;
        logic vunmask;
        logic [BUS_W*NUM_BUS-1:0] mbus;
        logic core_start;
        vme_core_req_t core;
        logic [3:0] fault;
        logic done;
        logic data_avail;
    } vme_state_bundle_t;
endpackage : vme_pkg

// file: vme_iface.sv
// Voting memory ECC interface datapath: voter, registers, Hamming code, fault control.
`timescale 1ns/10ps
// Functional notes
// - Simplex forwards selected bus, no voter fault.
// - Duplex ORs buses, mismatch flags both unless zero.
// - TMR outputs majority, flags disagreeing buses.
// - Voter is 11 bits, four buses.
// - Address register: 12 bits plus parity.
// - Data register: 32 bits plus parity.
// - Parity check over 13 address bits.
// - Parity check over 33 data bits.
// - Six-bit Hamming code on write data.
// - Odd overall parity over data and check.
// - Read syndrome over 38 code bits.
// - Overall parity check over 39 bits.
// - Correct syndrome bit only with parity error.
// - Multiple fault when exactly one check fails.
// - All-zero word is multiple fault, except clearing.
// - Fresh parity over corrected read data.
// - Block write on register or unmaskable faults.
// - Zero read data on address parity, multiple, unmaskable voter faults.
// - Fault code names accessors, except Hamming faults.
// - Output 33 bits on selected bus, zeroed on faults but always sent.
// - Address two beats, data three beats.
// - Grant count selects voter mode.
// - Redundant modes drive lowest, middle or highest bus.
// - Four-bit fault code encoding.
module vme_iface (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire vme_pkg::vme_req_t req_i,
    input wire logic [vme_pkg::BUS_W*vme_pkg::NUM_BUS-1:0] pbus_i,
    input wire logic [vme_pkg::WORD_W-1:0] core_rdata_i,
    input wire logic core_rvalid_i,
    output logic core_start_o,
    output vme_pkg::vme_core_req_t core_o,
    output logic [vme_pkg::BUS_W*vme_pkg::NUM_BUS-1:0] mbus_o,
    output logic data_avail_o,
    output logic [3:0] fault_o,
    output logic done_o
);
    import vme_pkg::*;

    vme_state_bundle_t s_r;
    vme_state_bundle_t s_nxt;
    logic [BUS_W-1:0] pb_s1_r [NUM_BUS];
    logic [BUS_W-1:0] pb_s2_r [NUM_BUS];
    logic [WORD_W-1:0] crd_s1_r;
    logic [WORD_W-1:0] crd_s2_r;
    logic [1:0] crv_s_r;

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [HAM_W-1:0] ham_gen(input logic [DATA_W-1:0] d);
        logic [HAM_W-1:0] c;
        logic [5:0] pos;
        c = '0;
        pos = 6'h0;
        for (int i = 0; i < DATA_W; i++) begin
            pos = dpos(i[5:0]);
            for (int k = 0; k < HAM_W; k++) begin
                if (pos[k]) begin
                    c[k] = c[k] ^ d[i];
                end
            end
        end
        return c;
    endfunction : ham_gen

    // Data bit i sits at the i-th non-power-of-two code position.
    function automatic logic [5:0] dpos(input logic [5:0] idx);
        logic [5:0] p;
        logic [5:0] n;
        p = 6'h0;
        n = 6'h0;
        for (int q = 3; q < 64; q++) begin
            if ((q & (q - 1)) != 0) begin
                if (n == idx) begin
                    p = q[5:0];
                end
                n = n + 6'h1;
            end
        end
        return p;
    endfunction : dpos

    function automatic logic [BUS_W-1:0] pick(input logic [NUM_BUS-1:0] g, input int rank);
        logic [BUS_W-1:0] v;
        int n;
        v = '0;
        n = 0;
        for (int b = 0; b < NUM_BUS; b++) begin
            if (g[b]) begin
                if (n == rank) begin
                    v = pb_s2_r[b];
                end
                n++;
            end
        end
        return v;
    endfunction : pick

    function automatic logic [1:0] pick_idx(input logic [NUM_BUS-1:0] g, input logic [1:0] rank);
        logic [1:0] v;
        logic [1:0] n;
        v = '0;
        n = '0;
        for (int b = 0; b < NUM_BUS; b++) begin
            if (g[b]) begin
                if (n == rank) begin
                    v = b[1:0];
                end
                n = n + 2'h1;
            end
        end
        return v;
    endfunction : pick_idx

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            for (int b = 0; b < NUM_BUS; b++) begin
                pb_s1_r[b] <= '0;
                pb_s2_r[b] <= '0;
            end
            crd_s1_r <= '0;
            crd_s2_r <= '0;
            crv_s_r <= '0;
        end else if (ce_i) begin
            for (int b = 0; b < NUM_BUS; b++) begin
                pb_s1_r[b] <= pbus_i[b*BUS_W +: BUS_W];
                pb_s2_r[b] <= pb_s1_r[b];
            end
            crd_s1_r <= core_rdata_i;
            crd_s2_r <= crd_s1_r;
            crv_s_r <= {crv_s_r[0], core_rvalid_i};
        end
    end

    // ************************************************************
    // Voter and read checks
    // ************************************************************
    logic [2:0] ngrant;
    logic [BUS_W-1:0] va;
    logic [BUS_W-1:0] vb;
    logic [BUS_W-1:0] vc;
    logic [BUS_W-1:0] vote;
    logic [NUM_BUS-1:0] vflt;
    logic vunmask;
    logic [HAM_W-1:0] syn;
    logic perr;
    logic mfault;
    logic [DATA_W-1:0] corr;
    logic [5:0] p;

    always_comb begin
        ngrant = 3'(s_r.grant[0]) + 3'(s_r.grant[1]) + 3'(s_r.grant[2]) + 3'(s_r.grant[3]);
        va = pick(s_r.grant, 0);
        vb = pick(s_r.grant, 1);
        vc = pick(s_r.grant, 2);
        vflt = '0;
        vunmask = 1'b0;
        case (ngrant)
            3'd2: begin
                vote = va | vb;
                if (va != vb && va != '0 && vb != '0) begin
                    vflt = s_r.grant;
                    vunmask = 1'b1;
                end
            end
            3'd3: begin
                vote = (va & vb) | (va & vc) | (vb & vc);
                vflt[pick_idx(s_r.grant, 2'd0)] = va != vote;
                vflt[pick_idx(s_r.grant, 2'd1)] = vb != vote;
                vflt[pick_idx(s_r.grant, 2'd2)] = vc != vote;
                vunmask = (va != vote) && (vb != vote); // Dissent on both the lowest and middle granted bus cannot be masked.
            end
            default: begin
                vote = va;
            end
        endcase
        syn = ham_gen(crd_s2_r[DATA_W-1:0]) ^ crd_s2_r[CODE_W-1:DATA_W];
        perr = ~^crd_s2_r;
        // A cleared word carries no check bits, so only the clear mode vouches for it.
        mfault = (crd_s2_r == '0) ? !s_r.clear_mode
            : ((syn != '0) ^ perr);
        corr = crd_s2_r[DATA_W-1:0];
        for (int i = 0; i < DATA_W; i++) begin
            p = dpos(i[5:0]);
            if (perr && syn == p) begin
                corr[i] = ~corr[i];
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    logic areg_err;
    logic dreg_err;
    logic [1:0] osel;
    logic [3:0] fcode;

    always_comb begin
        s_nxt = s_r;
        s_nxt.core_start = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.data_avail = 1'b0;
        s_nxt.mbus = '0;
        areg_err = ^s_r.addr == 1'b0;
        dreg_err = ^s_r.data == 1'b0;
        osel = (ngrant == 3'd1) ? pick_idx(s_r.grant, 2'd0) : pick_idx(s_r.grant, s_r.out_bus);
        fcode = FLT_NONE;
        for (int b = 0; b < NUM_BUS; b++) begin
            if (s_r.grant[b] && (s_r.vflt[b] || areg_err || dreg_err || s_r.bad)) begin
                fcode = (s_r.io_req ? FLT_IOP_BASE : FLT_PE_BASE) | 4'(b);
            end
        end
        case (s_r.st)
            ST_IDLE: begin
                if (req_i.valid) begin
                    // The fault code stands until the next access is taken.
                    s_nxt.fault = FLT_NONE;
                    s_nxt.st = ST_ADDR;
                    s_nxt.beat = '0;
                    s_nxt.wr = req_i.write;
                    s_nxt.grant = req_i.grant;
                    s_nxt.io_req = req_i.io_req;
                    s_nxt.out_bus = req_i.out_assign;
                    s_nxt.clear_mode = req_i.clear_mode;
                    s_nxt.vflt = '0;
                    s_nxt.vunmask = 1'b0;
                    s_nxt.bad = 1'b0;
                end
            end
            ST_ADDR: begin
                s_nxt.vflt = s_r.vflt | vflt;
                s_nxt.vunmask = s_r.vunmask | vunmask;
                s_nxt.beat = s_r.beat + 2'h1;
                if (s_r.beat == 2'h0) begin
                    s_nxt.addr[ADDR_W-1:BUS_W] = vote[ADDR_W-BUS_W-1:0];
                end else begin
                    s_nxt.addr[BUS_W-1:0] = vote;
                    s_nxt.addr[ADDR_W] = ~^{s_nxt.addr[ADDR_W-1:BUS_W], vote};
                    s_nxt.beat = '0;
                    s_nxt.st = s_r.wr ? ST_WDATA : ST_READ;
                    s_nxt.core_start = !s_r.wr;
                    s_nxt.core.write = 1'b0;
                    s_nxt.core.addr = {s_nxt.addr[ADDR_W-1:BUS_W], vote};
                end
            end
            ST_WDATA: begin
                s_nxt.vflt = s_r.vflt | vflt;
                s_nxt.vunmask = s_r.vunmask | vunmask;
                s_nxt.beat = s_r.beat + 2'h1;
                case (s_r.beat)
                    2'h0: s_nxt.data[DATA_W-1:22] = vote[9:0];
                    2'h1: s_nxt.data[21:BUS_W] = vote;
                    default: begin
                        s_nxt.data[BUS_W-1:0] = vote;
                        s_nxt.data[DATA_W] = ~^{s_r.data[DATA_W-1:BUS_W], vote};
                        s_nxt.st = ST_WRITE;
                    end
                endcase
            end
            ST_WRITE: begin
                // Masked voter faults are still reported, though the write goes ahead.
                s_nxt.fault = (areg_err || dreg_err || s_r.vflt != '0) ? fcode : FLT_NONE;
                if (!(areg_err || dreg_err || s_r.vunmask)) begin
                    s_nxt.core_start = 1'b1;
                    s_nxt.core.write = 1'b1;
                    s_nxt.core.addr = s_r.addr[ADDR_W-1:0];
                    s_nxt.core.data = {1'b0, ham_gen(s_r.data[DATA_W-1:0]),
                        s_r.data[DATA_W-1:0]};
                    s_nxt.core.data[WORD_W-1] = ~^{ham_gen(s_r.data[DATA_W-1:0]),
                        s_r.data[DATA_W-1:0]};
                end
                s_nxt.done = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            ST_READ: begin
                if (crv_s_r[1]) begin
                    s_nxt.bad = mfault;
                    if (areg_err || s_r.vunmask || mfault) begin
                        s_nxt.rdata = '0;
                    end else begin
                        s_nxt.rdata = {~^corr, corr};
                    end
                    s_nxt.fault = (areg_err || s_r.vflt != '0) ? fcode
                        : (mfault ? FLT_INTERNAL : FLT_NONE);
                    s_nxt.beat = '0;
                    s_nxt.st = ST_OUT;
                end
            end
            ST_OUT: begin
                // Zero-forced words still go out so the requester is not left waiting.
                s_nxt.mbus[osel*BUS_W +: BUS_W] = s_r.rdata[DATA_W - s_r.beat*BUS_W -: BUS_W];
                s_nxt.data_avail = 1'b1;
                s_nxt.beat = s_r.beat + 2'h1;
                if (s_r.beat == 2'h2) begin
                    s_nxt.done = 1'b1;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.out_bus <= SEL_RESET;
            s_r.addr[ADDR_W] <= 1'b1;
            s_r.data[DATA_W] <= 1'b1;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign core_start_o = s_r.core_start;
    assign core_o = s_r.core;
    assign mbus_o = s_r.mbus;
    assign data_avail_o = s_r.data_avail;
    assign fault_o = s_r.fault;
    assign done_o = s_r.done;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_simplex_clean: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ngrant == 3'd1 |-> vflt == '0) else $error("simplex voter fault");
    chk_duplex_or: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ngrant == 3'd2 |-> vote == (va | vb)) else $error("duplex not OR");
    chk_tmr_vote: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ngrant == 3'd3 && va == vb |-> vote == va) else $error("tmr majority wrong");
    chk_write_block: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && s_r.st == ST_WRITE && s_r.vunmask |=> !core_start_o) else $error("bad write");
    chk_read_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && s_r.st == ST_READ && crv_s_r[1] && mfault |=> s_r.rdata == '0)
        else $error("multi fault not zeroed");
    chk_out_parity: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_r.st == ST_OUT |-> ^s_r.rdata == 1'b1 || s_r.rdata == '0) else $error("out parity");
    chk_code_parity: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        core_start_o && core_o.write |-> ^core_o.data == 1'b1) else $error("odd parity");
    sequence out_three;
        data_avail_o [*3] ##1 !data_avail_o;
    endsequence
    chk_three_beats: assert property (@(posedge clk_sys_i) disable iff (reset_i || !ce_i)
        $rose(data_avail_o) |-> out_three) else $error("data beats");
endmodule : vme_iface

// file: vme_core_model.sv
// Behavioural core store that answers the core cycles of the interface.
`timescale 1ns/10ps
module vme_core_model (
    input wire logic clk_sys_i,
    input wire logic core_start_i,
    input wire vme_pkg::vme_core_req_t core_i,
    input wire logic [3:0] lat_i,
    input wire logic [vme_pkg::WORD_W-1:0] flip_i,
    input wire logic zero_i,
    output logic [vme_pkg::WORD_W-1:0] rdata_o,
    output logic rvalid_o
);
    import vme_pkg::*;
    logic [WORD_W-1:0] mem [int];
    logic [WORD_W-1:0] word;
    initial begin
        rvalid_o = 1'b0;
        rdata_o = '0;
    end
    // Valid is a short pulse, so a stale level cannot start the next read.
    always @(posedge clk_sys_i) begin
        if (core_start_i === 1'b1 && core_i.write === 1'b1) begin
            mem[int'(core_i.addr)] = core_i.data;
        end else if (core_start_i === 1'b1) begin
            word = mem.exists(int'(core_i.addr)) ? mem[int'(core_i.addr)] : '0;
            repeat (lat_i) @(posedge clk_sys_i);
            rdata_o <= zero_i ? '0 : word ^ flip_i;
            rvalid_o <= 1'b1;
            repeat (2) @(posedge clk_sys_i);
            rvalid_o <= 1'b0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule : vme_core_model

// file: test_vme_iface.sv
// Self-checking testbench of the voting memory ECC interface.
`timescale 1ns/10ps
module test_vme_iface;
    import vme_pkg::*;
    typedef struct packed {
        logic rd;
        logic cw;
        logic chkd;
        logic [3:0] flt;
        logic [3:0] fm;
        logic [32:0] rdat;
        logic [1:0] bus;
        vme_core_req_t core;
    } vme_note_t;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    vme_req_t req = '0;
    logic [43:0] pbus = '0;
    logic [38:0] crd;
    logic crv;
    logic cst;
    vme_core_req_t core;
    logic [43:0] mbus;
    logic dav;
    logic [3:0] flt;
    logic done;
    logic [3:0] lat = 4'h2;
    logic [38:0] flip = '0;
    logic zero = 1'b0;
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'h27b23d09;
    vme_note_t q[$];
    logic [32:0] acc;
    int nb = 0;
    int ns = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    vme_iface dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .req_i(req),
        .pbus_i(pbus), .core_rdata_i(crd), .core_rvalid_i(crv), .core_start_o(cst),
        .core_o(core), .mbus_o(mbus), .data_avail_o(dav), .fault_o(flt), .done_o(done));
    vme_core_model mdl (.clk_sys_i(clk_sys_i), .core_start_i(cst), .core_i(core),
        .lat_i(lat), .flip_i(flip), .zero_i(zero), .rdata_o(crd), .rvalid_o(crv));
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [38:0] enc(input logic [31:0] d);
        int p;
        int i;
        int k;
        logic [5:0] h;
        p = 2;
        h = '0;
        for (i = 0; i < 32; i++) begin
            p++;
            while ((p & (p - 1)) == 0) p++;
            for (k = 0; k < 6; k++) begin
                if (p[k]) h[k] ^= d[i];
            end
        end
        return {~^{h, d}, h, d};
    endfunction : enc
    function automatic logic [10:0] beat(input logic [11:0] a, input logic [31:0] d, input int k);
        case (k)
            0: return {10'h0, a[11]};
            1: return a[10:0];
            2: return {1'b0, d[31:22]};
            3: return d[21:11];
            default: return d[10:0];
        endcase
    endfunction : beat
    task automatic op(input logic wr, input logic [3:0] g, input logic io, input logic [1:0] oa,
        input logic clr, input logic [11:0] ad, input logic [3:0][31:0] d, input logic [3:0] f,
        input logic [3:0] fm, input logic cw, input logic [31:0] xd, input logic [1:0] ob);
        vme_note_t n;
        int k;
        int b;
        int t;
        n = {~wr, cw, ~clr, f, fm, (f == FLT_INTERNAL) ? 33'h0 : {~^xd, xd}, ob,
            wr, ad, enc(xd)};
        lat = 4'($random(seed)) & 4'h7;
        q.push_back(n);
        for (k = 0; k < 5; k++) begin
            @(negedge clk_sys_i);
            for (b = 0; b < 4; b++) pbus[b*11+:11] = beat(ad, d[b], k);
            req = (k == 1) ? {1'b1, wr, g, io, oa, clr} : '0;
        end
        @(negedge clk_sys_i);
        pbus = ~pbus;
        t = 0;
        while (done !== 1'b1 && t < 400) begin
            @(posedge clk_sys_i);
            t++;
        end
        if (t >= 400) chk("done_wait", t, 0);
        @(negedge clk_sys_i);
    endtask : op
    // ************************************************************
    // Monitor: one note is retired at each completion pulse.
    // ************************************************************
    always @(posedge clk_sys_i) begin
        if (!reset_i && q.size() > 0) begin
            if (dav === 1'b1) begin
                acc = {acc[21:0], mbus[q[0].bus*11+:11]};
                nb++;
                chk("idle_buses", mbus & ~(44'h7ff << (q[0].bus * 11)), 0);
            end
            if (cst === 1'b1) begin
                ns++;
                chk("core_addr", {core.write, core.addr}, {q[0].core.write, q[0].core.addr});
                if (q[0].core.write) chk("core_word", core.data, q[0].core.data);
            end
            if (done === 1'b1) begin
                chk("fault", flt & q[0].fm, q[0].flt);
                chk("core_starts", ns, q[0].cw);
                chk("out_beats", nb, q[0].rd ? 3 : 0);
                if (q[0].rd && q[0].chkd) chk("read_data", acc, q[0].rdat);
                void'(q.pop_front());
                nb = 0;
                ns = 0;
            end
        end
    end
    initial begin
        #(5ns * 40000);
        chk("watchdog", 1, 0);
        finish_test();
    end
    initial begin
        logic [11:0] ad;
        logic [31:0] dw;
        logic [3:0][31:0] dd;
        logic [3:0] f;
        logic clr;
        int b;
        int r;
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        reset_i = 1'b0;
        // Noise on the unselected buses shows that they are ignored.
        for (b = 0; b < 4; b++) begin
            ad = 12'($random(seed));
            dw = $random(seed);
            dd = {$random(seed), $random(seed), $random(seed), $random(seed)};
            dd[b] = dw;
            op(1, 4'h1 << b, 0, 0, 0, ad, dd, FLT_NONE, 4'hf, 1, dw, b);
            op(0, 4'h1 << b, 0, 0, 0, ad, {4{dw}}, FLT_NONE, 4'hf, 1, dw, b);
        end
        $display("test simplex done");
        dd = '0;
        dd[0] = dw;
        op(1, 4'h5, 0, 0, 0, ad, dd, FLT_NONE, 4'hf, 1, dw, 0);
        dd[2] = dw ^ 32'h1;
        op(1, 4'h5, 0, 0, 0, ad, dd, 4'h8, 4'hc, 0, dw, 0);
        op(0, 4'h5, 0, 0, 0, ad, {4{dw}}, FLT_NONE, 4'hf, 1, dw, 0);
        $display("test duplex done");
        dw = $random(seed);
        dd = {dw ^ 32'h10000, dw, dw, dw};
        op(1, 4'he, 1, 0, 0, ad, dd, FLT_IOP_BASE | 4'h3, 4'hf, 1, dw, 3);
        for (b = 0; b < 3; b++) begin
            op(0, 4'he, 0, b, 0, ad, {4{dw}}, FLT_NONE, 4'hf, 1, dw, b + 1);
        end
        $display("test tmr done");
        r = {$random(seed)} % 32;
        for (b = 0; b < 6; b++) begin
            flip = '0;
            zero = 1'b0;
            clr = 1'b0;
            f = FLT_INTERNAL;
            case (b)
                0: begin flip[r] = 1'b1; f = FLT_NONE; end
                1: begin flip[32 + r % 6] = 1'b1; f = FLT_NONE; end
                2: flip[38] = 1'b1;
                3: begin flip[r] = 1'b1; flip[(r + 1) % 32] = 1'b1; end
                4: zero = 1'b1;
                default: begin zero = 1'b1; clr = 1'b1; f = FLT_NONE; end
            endcase
            op(0, 4'h1, 0, 0, clr, ad, {4{dw}}, f, 4'hf, 1, dw, 0);
        end
        $display("test ecc done");
        finish_test();
    end
endmodule : test_vme_iface
